//--- src/esbm_pkg.sv
// Constants, register map and state type for the energy buffer mode control block.
// Behaviour
// - A command write with bit 0 set enables on-demand operation; clear disables it.
// - A command write with bit 1 set enables continuous operation; clear disables it.
// - In continuous operation the force-active bit moves straight to the active state.
// - A command write with bit 3 set clears the optimizer result of the profile.
// - Bit 7 of the auto configuration register enables or disables auto operation.
// - Without auto support the auto-enable bit resets to 0 and never becomes 1.
// - In continuous operation the charger restarts whenever the capacitor drops below target.
// - In continuous operation the capacitor recharges by itself after an energy pulse.
// - In continuous operation ready rises once the capacitor reaches its target.
// - Continuous operation returns to standby only when continuous and force bits clear.
// - On-demand charges first, then regulates the output, ready once it can deliver.
// - On-demand operation ends when the on-demand and force bits are both clear.
// - With auto enabled a trigger rising edge sets on-demand and starts one cycle.
// - In auto operation charging completion enters active; ready once output regulates.
// - After a short trigger, active ends once load stays below no-load long enough.
// - After a long trigger, active ends when the trigger pin falls.
// - A trigger falling during the charge state counts as a short trigger.
// - With auto support, reset gives auto on, 3.0 V, 8 mA and profile 1.
// - Mode changes between continuous, on-demand and auto are accepted at any time.
// - Status bit 0 always mirrors the ready output.
// - Ready drops when the controlling mode bits clear or the capacitor is depleted.
package esbm_pkg;
  localparam logic [6:0] STATUS_ADDR   = 7'h00;
  localparam logic [6:0] PROF_HI_ADDR  = 7'h07;
  localparam logic [6:0] CMD_ADDR      = 7'h08;
  localparam logic [6:0] AUTO_CFG_ADDR = 7'h0b;
  localparam int         CMD_EOD_BIT   = 0;
  localparam int         CMD_ECM_BIT   = 1;
  localparam int         CMD_ACT_BIT   = 2;
  localparam int         CMD_RSTPF_BIT = 3;
  localparam int         CMD_PROF_LSB  = 4;
  localparam int         PROF_HI_LSB   = 0;
  localparam int         AUTO_EN_BIT   = 7;
  localparam int         STATUS_RDY    = 0;
  localparam logic [5:0] PROF_RST      = 6'h01;
  // Converter codes for 3.0 V and 8 mA; the analog trim tables decide the encoding.
  localparam logic [3:0] VSET_RST      = 4'h0;
  localparam logic [2:0] ICH_RST       = 3'h0;
  localparam int         CLK_MHZ       = 50;
  localparam int         NL_TIME_US    = 1000;
  localparam int         NL_CYCLES_DEF = NL_TIME_US * CLK_MHZ;
  localparam int         SYNC_STAGES   = 2;
  typedef enum logic [1:0] {ESBM_STANDBY, ESBM_CHARGE, ESBM_ACTIVE} esbm_state_t;
endpackage : esbm_pkg

//--- src/esbm_sync.sv
// Two-stage synchroniser for a group of asynchronous input levels.
`timescale 1ns/100ps
module esbm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] d_sync
);
  logic [WIDTH-1:0] meta_r;

  // The first stage feeds only the second stage, so metastability never reaches logic.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      meta_r <= '0;
      d_sync <= '0;
    end
    else
    begin
      meta_r <= d_in;
      d_sync <= meta_r;
    end
  end
endmodule : esbm_sync

//--- src/esbm_mode_ctrl.sv
// Mode, state and ready control of the battery buffering converter.
`timescale 1ns/100ps
module esbm_mode_ctrl #(
  parameter bit AUTO_CAPABLE = 1'b1,
  parameter int NL_CYCLES    = esbm_pkg::NL_CYCLES_DEF
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       start_pin,
  input  wire logic       cap_below_target,
  input  wire logic       cap_depleted,
  input  wire logic       output_in_reg,
  input  wire logic       load_below_nl,
  output logic            ready,
  output logic            charge_en,
  output logic            active_en,
  output logic            opt_clear,
  output logic      [5:0] opt_profile,
  output logic      [3:0] vset_code,
  output logic      [2:0] ich_code
);
  logic [4:0]             pins_s;
  logic                   start_s;
  logic                   cap_below_s;
  logic                   cap_dep_s;
  logic                   out_reg_s;
  logic                   load_nl_s;
  logic                   start_d_r;
  logic                   start_rise;
  logic                   start_fall;
  logic                   cmd_wr;
  logic                   cfg_wr;
  logic                   prof_hi_wr;
  logic                   auto_trig;
  logic                   auto_end;
  logic                   eod_r;
  logic                   ecm_r;
  logic                   act_r;
  logic                   automode_r;
  logic                   auto_cycle_r;
  logic                   long_r;
  logic                   any_mode;
  logic                   cont_mode;
  logic                   nl_done;
  logic [31:0]            nl_cnt_r;
  logic [5:0]             prof_r;
  esbm_pkg::esbm_state_t  state_r;
  esbm_pkg::esbm_state_t  state_nxt;

  esbm_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d_in   ({start_pin, cap_below_target, cap_depleted, output_in_reg, load_below_nl}),
    .d_sync (pins_s)
  );

  assign start_s     = pins_s[4];
  assign cap_below_s = pins_s[3];
  assign cap_dep_s   = pins_s[2];
  assign out_reg_s   = pins_s[1];
  assign load_nl_s   = pins_s[0];

  always_ff @(posedge clk)
  begin
    if (!resetn)
      start_d_r <= 1'b0;
    else
      start_d_r <= start_s;
  end

  assign start_rise = start_s && !start_d_r;
  assign start_fall = !start_s && start_d_r;
  assign cmd_wr     = reg_wr_en && (reg_addr == esbm_pkg::CMD_ADDR);
  assign cfg_wr     = reg_wr_en && (reg_addr == esbm_pkg::AUTO_CFG_ADDR);
  assign prof_hi_wr = reg_wr_en && (reg_addr == esbm_pkg::PROF_HI_ADDR);
  assign auto_trig  = automode_r && start_rise;
  assign any_mode   = eod_r || ecm_r || act_r;
  assign cont_mode  = ecm_r && !eod_r;
  assign nl_done    = (nl_cnt_r == 32'(NL_CYCLES - 1));
  assign auto_end   = (state_r == esbm_pkg::ESBM_ACTIVE) && auto_cycle_r && !auto_trig
                      && (long_r ? !start_s : nl_done);

  // A trigger edge in the same cycle as a command write wins, so no start is lost.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      eod_r <= 1'b0;
    else if (auto_trig)
      eod_r <= 1'b1;
    else if (cmd_wr)
      eod_r <= reg_wdata[esbm_pkg::CMD_EOD_BIT];
    else if (auto_end)
      eod_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ecm_r <= 1'b0;
      act_r <= 1'b0;
    end
    else if (cmd_wr)
    begin
      ecm_r <= reg_wdata[esbm_pkg::CMD_ECM_BIT];
      act_r <= reg_wdata[esbm_pkg::CMD_ACT_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      automode_r <= AUTO_CAPABLE;
    else if (cfg_wr)
      automode_r <= reg_wdata[esbm_pkg::AUTO_EN_BIT] && AUTO_CAPABLE;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      prof_r    <= esbm_pkg::PROF_RST;
      vset_code <= esbm_pkg::VSET_RST;
      ich_code  <= esbm_pkg::ICH_RST;
    end
    else
    begin
      if (cmd_wr)
        prof_r[3:0] <= reg_wdata[esbm_pkg::CMD_PROF_LSB +: 4];
      if (prof_hi_wr)
        prof_r[5:4] <= reg_wdata[esbm_pkg::PROF_HI_LSB +: 2];
    end
  end

  assign opt_profile = prof_r;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      opt_clear <= 1'b0;
    else
      opt_clear <= cmd_wr && reg_wdata[esbm_pkg::CMD_RSTPF_BIT];
  end

  // A software command write hands the cycle back to serial control.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      auto_cycle_r <= 1'b0;
      long_r       <= 1'b0;
    end
    else if (auto_trig)
    begin
      auto_cycle_r <= 1'b1;
      long_r       <= 1'b1;
    end
    else
    begin
      if (cmd_wr || auto_end)
        auto_cycle_r <= 1'b0;
      if (state_r == esbm_pkg::ESBM_CHARGE && start_fall)
        long_r <= 1'b0;
    end
  end

  // The no-load filter only counts unbroken quiet time after a short trigger.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      nl_cnt_r <= '0;
    else if (state_r == esbm_pkg::ESBM_ACTIVE && auto_cycle_r && !long_r && load_nl_s)
    begin
      if (!nl_done)
        nl_cnt_r <= nl_cnt_r + 32'd1;
    end
    else
      nl_cnt_r <= '0;
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      esbm_pkg::ESBM_STANDBY:
      begin
        if (act_r)
          state_nxt = esbm_pkg::ESBM_ACTIVE;
        else if (ecm_r || eod_r)
          state_nxt = esbm_pkg::ESBM_CHARGE;
      end
      esbm_pkg::ESBM_CHARGE:
      begin
        if (!any_mode)
          state_nxt = esbm_pkg::ESBM_STANDBY;
        else if (act_r)
          state_nxt = esbm_pkg::ESBM_ACTIVE;
        else if (eod_r && !cap_below_s)
          state_nxt = esbm_pkg::ESBM_ACTIVE;
      end
      esbm_pkg::ESBM_ACTIVE:
      begin
        if (!any_mode)
          state_nxt = esbm_pkg::ESBM_STANDBY;
        else if (!act_r && !eod_r)
          state_nxt = esbm_pkg::ESBM_CHARGE;
      end
      default:
        state_nxt = esbm_pkg::ESBM_STANDBY;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      state_r <= esbm_pkg::ESBM_STANDBY;
    else
      state_r <= state_nxt;
  end

  // Charging in continuous mode is a refresh: it only runs while below target.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      charge_en <= 1'b0;
      active_en <= 1'b0;
    end
    else
    begin
      charge_en <= (state_r == esbm_pkg::ESBM_CHARGE) && cap_below_s;
      active_en <= (state_r == esbm_pkg::ESBM_ACTIVE);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      ready <= 1'b0;
    else if (cap_dep_s || !any_mode)
      ready <= 1'b0;
    else if (cont_mode && state_r == esbm_pkg::ESBM_CHARGE && !cap_below_s)
      ready <= 1'b1;
    else if (!cont_mode && state_r == esbm_pkg::ESBM_ACTIVE && out_reg_s)
      ready <= 1'b1;
  end

  // Only the status register reads back; the command registers are write-only.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd_en)
    begin
      if (reg_addr == esbm_pkg::STATUS_ADDR)
        reg_rdata <= {7'h00, ready};
      else
        reg_rdata <= 8'h00;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_eod_write: assert property (cmd_wr && !auto_trig |=> eod_r == $past(reg_wdata[0]))
    else $error("On-demand bit did not follow the command write.");
  a_ecm_write: assert property (cmd_wr |=> ecm_r == $past(reg_wdata[1]))
    else $error("Continuous bit did not follow the command write.");
  a_force_act: assert property (state_r == esbm_pkg::ESBM_CHARGE && act_r |=>
    state_r == esbm_pkg::ESBM_ACTIVE ##1 active_en)
    else $error("Force active did not reach the active state in time.");
  a_opt_clear: assert property (opt_clear |-> $past(cmd_wr && reg_wdata[3]))
    else $error("Optimizer clear pulsed without a command write.");
  a_auto_cfg: assert property (cfg_wr |=> automode_r == ($past(reg_wdata[7]) && AUTO_CAPABLE))
    else $error("Auto enable did not follow the configuration write.");
  a_refresh_chg: assert property (state_r == esbm_pkg::ESBM_CHARGE && cap_below_s |=> charge_en)
    else $error("Charger not enabled while below target.");
  a_auto_recharge: assert property (state_r == esbm_pkg::ESBM_ACTIVE && ecm_r && !act_r &&
    !eod_r |=> state_r == esbm_pkg::ESBM_CHARGE)
    else $error("No recharge after the active pulse.");
  a_mode_standby: assert property (!any_mode |=> state_r == esbm_pkg::ESBM_STANDBY && !ready)
    else $error("Device did not return to standby.");
  a_trig_start: assert property (automode_r && start_rise |=> eod_r ##1
    state_r != esbm_pkg::ESBM_STANDBY)
    else $error("Trigger edge did not start a cycle.");
  a_long_end: assert property (auto_end && long_r && !cmd_wr |=> !eod_r)
    else $error("Long trigger fall did not end the active state.");
  a_depl_ready: assert property (cap_dep_s |=> !ready)
    else $error("Ready stayed high with a depleted capacitor.");
  a_trig_ignored: assert property (!automode_r && !cmd_wr |=> $stable(eod_r))
    else $error("On-demand bit changed without a write in manual mode.");
  a_status_mirror: assert property (reg_rd_en && reg_addr == esbm_pkg::STATUS_ADDR |=>
    reg_rdata[0] == $past(ready))
    else $error("Status bit does not mirror ready.");
  a_cont_ready: assert property (cont_mode && state_r == esbm_pkg::ESBM_CHARGE &&
    !cap_below_s && !cap_dep_s |=> ready)
    else $error("Ready did not rise at the continuous charge target.");
  a_od_ready: assert property (!cont_mode && any_mode &&
    state_r == esbm_pkg::ESBM_ACTIVE && out_reg_s && !cap_dep_s |=> ready)
    else $error("Ready did not rise once the output regulated.");
  a_od_charge: assert property (state_r == esbm_pkg::ESBM_CHARGE && eod_r && !act_r &&
    cap_below_s |=> state_r == esbm_pkg::ESBM_CHARGE)
    else $error("On-demand left the charge state before the target.");
  a_charge_done: assert property (state_r == esbm_pkg::ESBM_CHARGE && eod_r &&
    !cap_below_s |=> state_r == esbm_pkg::ESBM_ACTIVE)
    else $error("Charge completion did not enter the active state.");
  a_active_out: assert property (state_r == esbm_pkg::ESBM_ACTIVE |=> active_en)
    else $error("Output converter not enabled in the active state.");
  a_charge_off: assert property (state_r != esbm_pkg::ESBM_CHARGE |=> !charge_en)
    else $error("Charger enabled outside the charge state.");
  a_mode_hold: assert property (state_r != esbm_pkg::ESBM_STANDBY && (ecm_r || act_r) |=>
    state_r != esbm_pkg::ESBM_STANDBY)
    else $error("Continuous operation left for standby with a mode bit set.");
  a_short_end: assert property (auto_end && !long_r && !cmd_wr |=> !eod_r)
    else $error("Quiet load did not end the short trigger cycle.");
  a_nl_restart: assert property (state_r == esbm_pkg::ESBM_ACTIVE && auto_cycle_r &&
    !long_r && !load_nl_s |=> nl_cnt_r == 32'd0)
    else $error("No-load filter did not restart on load activity.");
  a_fall_short: assert property (state_r == esbm_pkg::ESBM_CHARGE && start_fall |=>
    !long_r)
    else $error("Trigger fall in the charge state not taken as short.");

  c_auto_short: cover property (auto_end && !long_r);
  c_auto_long: cover property (auto_end && long_r);
  c_cont_ready: cover property (cont_mode && ready ##1 state_r == esbm_pkg::ESBM_ACTIVE);
  c_od_ready: cover property (eod_r && !auto_cycle_r && $rose(ready));
  c_depl_drop: cover property (cap_dep_s && ready ##1 !ready);
endmodule : esbm_mode_ctrl

//--- verif/esbm_env_model.sv
// Storage capacitor and output stage model facing the mode control block.
`timescale 1ns/100ps
module esbm_env_model #(
  parameter int CHG_CYCLES = 600
) (
  input  wire logic clk,
  input  wire logic charge_en,
  input  wire logic active_en,
  input  wire logic drain,
  output logic      cap_below_target,
  output logic      output_in_reg
);
  int   level_r = 0;
  logic act_d_r = 1'b0;
  // The level only climbs while charging, so a charger that never starts never reaches target.
  always_ff @(posedge clk)
  begin
    if (drain)
      level_r <= 0;
    else if (charge_en && level_r < CHG_CYCLES)
      level_r <= level_r + 1;
  end
  always_ff @(posedge clk)
  begin
    act_d_r <= active_en;
  end
  assign cap_below_target = (level_r < CHG_CYCLES);
  assign output_in_reg    = act_d_r & active_en;
endmodule : esbm_env_model

//--- verif/tb_esbm_mode_ctrl.sv
// Self-checking bench for the mode and state control block.
`timescale 1ns/100ps
module tb_esbm_mode_ctrl;
  localparam logic [6:0] CMD = esbm_pkg::CMD_ADDR;
  localparam logic [6:0] CFG = esbm_pkg::AUTO_CFG_ADDR;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       reg_wr_en = 1'b0;
  logic       reg_rd_en = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       start_pin = 1'b0;
  logic       cap_depleted = 1'b0;
  logic       load_below_nl = 1'b0;
  logic       drain = 1'b0;
  logic [7:0] reg_rdata;
  logic       cap_below_target;
  logic       output_in_reg;
  logic       ready;
  logic       charge_en;
  logic       active_en;
  logic       opt_clear;
  logic [5:0] opt_profile;
  logic [3:0] vset_code;
  logic [2:0] ich_code;
  logic       nb_charge_en;
  int         err_count = 0;
  int         checks = 0;

  initial
  begin
    forever #10 clk = ~clk;
  end

  esbm_mode_ctrl #(.AUTO_CAPABLE(1'b1), .NL_CYCLES(20)) u_esbm_mode_ctrl (
    .clk(clk), .resetn(resetn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .start_pin(start_pin), .cap_below_target(cap_below_target),
    .cap_depleted(cap_depleted), .output_in_reg(output_in_reg),
    .load_below_nl(load_below_nl), .ready(ready), .charge_en(charge_en),
    .active_en(active_en), .opt_clear(opt_clear), .opt_profile(opt_profile),
    .vset_code(vset_code), .ich_code(ich_code));
  // Variant without auto support shares the write bus and pins; it must never start from the trigger pin.
  esbm_mode_ctrl #(.AUTO_CAPABLE(1'b0), .NL_CYCLES(20)) u_esbm_mode_ctrl_b (
    .clk(clk), .resetn(resetn), .reg_wr_en(reg_wr_en), .reg_rd_en(1'b0),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(),
    .start_pin(start_pin), .cap_below_target(cap_below_target),
    .cap_depleted(cap_depleted), .output_in_reg(output_in_reg),
    .load_below_nl(load_below_nl), .ready(), .charge_en(nb_charge_en),
    .active_en(), .opt_clear(), .opt_profile(), .vset_code(), .ich_code());
  esbm_env_model u_esbm_env_model (
    .clk(clk), .charge_en(charge_en), .active_en(active_en), .drain(drain),
    .cap_below_target(cap_below_target), .output_in_reg(output_in_reg));

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string name);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    @(negedge clk);
    chk(name, reg_rdata, exp);
  endtask : rd

  // Selector 0 is ready, 1 is charge_en, 2 is active_en.
  task automatic wait_on(input int sel, input logic lvl, input int bound);
    logic s;
    for (int i = 0; i <= bound; i++)
    begin
      s = (sel == 0) ? ready : (sel == 1) ? charge_en : active_en;
      if (s === lvl)
      begin
        checks++;
        return;
      end
      @(negedge clk);
    end
    err_count++;
    $display("MISMATCH wait %0d expected %b seen timeout", sel, lvl);
    final_report();
  endtask : wait_on

  task automatic empty_cap;
    drain = 1'b1;
    @(negedge clk);
    drain = 1'b0;
  endtask : empty_cap

  initial
  begin
    repeat (3) @(negedge clk);
    // Register traffic starts only once reset has settled.
    resetn = 1'b1;
    chk("profile", {2'b00, opt_profile}, 8'h01);
    chk("outputs", {5'b0, ready, charge_en, active_en}, 8'h00);
    chk("setpoints", {1'b0, vset_code, ich_code}, {1'b0, esbm_pkg::VSET_RST, esbm_pkg::ICH_RST});
    rd(esbm_pkg::STATUS_ADDR, 8'h00, "status");
    wr(7'h7f, 8'hff);
    rd(7'h7f, 8'h00, "unmapped");
    wr(CMD, 8'h01);
    wait_on(1, 1'b1, 10);
    chk("early_active", {7'b0, active_en}, 8'h00);
    wait_on(0, 1'b1, 1000);
    chk("od_active", {7'b0, active_en}, 8'h01);
    rd(esbm_pkg::STATUS_ADDR, 8'h01, "status");
    wr(CMD, 8'h00);
    wait_on(0, 1'b0, 10);
    // The output converter enable follows the state one cycle after ready drops.
    @(negedge clk);
    chk("od_end", {6'b0, charge_en, active_en}, 8'h00);
    empty_cap();
    wr(CMD, 8'h02);
    wait_on(0, 1'b1, 1000);
    chk("cm_idle", {7'b0, active_en}, 8'h00);
    empty_cap();
    wait_on(1, 1'b1, 10);
    chk("cm_ready", {7'b0, ready}, 8'h01);
    wait_on(1, 1'b0, 1000);
    wr(CMD, 8'h06);
    wait_on(2, 1'b1, 5);
    empty_cap();
    wr(CMD, 8'h04);
    repeat (5) @(negedge clk);
    chk("act_holds", {7'b0, active_en}, 8'h01);
    wr(CMD, 8'h02);
    wait_on(1, 1'b1, 10);
    wr(CMD, 8'h00);
    wait_on(0, 1'b0, 10);
    wr(CMD, 8'h28);
    chk("clr_pulse", {1'b0, opt_clear, opt_profile}, 8'h42);
    @(negedge clk);
    chk("clr_end", {7'b0, opt_clear}, 8'h00);
    wr(CMD, 8'h10);
    chk("no_clr", {1'b0, opt_clear, opt_profile}, 8'h01);
    @(negedge clk);
    wr(esbm_pkg::PROF_HI_ADDR, 8'h01);
    chk("prof_hi", {2'b00, opt_profile}, 8'h11);
    @(negedge clk);
    wr(CMD, 8'h01);
    wait_on(0, 1'b1, 1000);
    cap_depleted = 1'b1;
    wait_on(0, 1'b0, 5);
    cap_depleted = 1'b0;
    wr(CMD, 8'h00);
    repeat (5) @(negedge clk);
    empty_cap();
    start_pin = 1'b1;
    wait_on(1, 1'b1, 10);
    wait_on(0, 1'b1, 1000);
    chk("auto_act", {6'b0, active_en, nb_charge_en}, 8'h02);
    start_pin = 1'b0;
    wait_on(0, 1'b0, 10);
    wr(CFG, 8'h80);
    empty_cap();
    start_pin = 1'b1;
    repeat (500) @(negedge clk);
    start_pin = 1'b0;
    wait_on(0, 1'b1, 1000);
    load_below_nl = 1'b1;
    repeat (10) @(negedge clk);
    chk("nl_early", {6'b0, ready, nb_charge_en}, 8'h02);
    wait_on(0, 1'b0, 30);
    load_below_nl = 1'b0;
    wr(CFG, 8'h00);
    empty_cap();
    start_pin = 1'b1;
    repeat (20) @(negedge clk);
    chk("auto_off", {7'b0, charge_en}, 8'h00);
    start_pin = 1'b0;
    wr(CMD, 8'h01);
    wait_on(1, 1'b1, 10);
    wr(CMD, 8'h00);
    repeat (5) @(negedge clk);
    final_report();
  end
endmodule : tb_esbm_mode_ctrl
